// file: port_pin_function_select.sv
// pin control logic for the narrow, input-only and wide ports
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "port_pin_regs.svh"

module port_pin_function_select
  import port_pin_pkg::*;
#(
  parameter int P5_W = 6,
  parameter int P7_W = 8,
  parameter int P9_W = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [5:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // narrow port pins
  input wire logic [P5_W-1:0] p5_pin_i,
  output logic [P5_W-1:0] p5_pin_o,
  output logic [P5_W-1:0] p5_pin_oe_o,
  // narrow port peripheral side
  input wire logic [P5_W-1:0] p5_periph_out_i,
  input wire logic [P5_W-1:0] p5_periph_oe_i,
  input wire logic [P5_W-1:0] realtime_pulse_out_i,
  output logic [P5_W-1:0] p5_periph_in_o,
  output logic [P5_W-1:0] key_return_input_o,
  // input-only port
  input wire logic [P7_W-1:0] p7_pin_i,
  output logic [P7_W-1:0] analog_input_channel_o,
  // wide port pins
  input wire logic [P9_W-1:0] p9_pin_i,
  output logic [P9_W-1:0] p9_pin_o,
  output logic [P9_W-1:0] p9_pin_oe_o,
  // wide port peripheral side
  input wire logic [P9_W-1:0] ext_addr_i,
  input wire logic [P9_W-1:0] p9_periph_out_i,
  input wire logic [P9_W-1:0] p9_periph_oe_i,
  output logic [P9_W-1:0] p9_periph_in_o,
  output logic [2:0] timer_capture_input_o,
  output logic [1:0] p9_key_return_o,
  output logic [2:0] external_interrupt_input_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [P5_W-1:0] p5_dir_reg;
  logic [P5_W-1:0] p5_mode_reg;
  logic [P5_W-1:0] p5_func_reg;
  logic [P5_W-1:0] p5_latch_reg;
  logic [P9_W-1:0] p9_latch_reg;
  logic [P9_W-1:0] p9_dir_reg;
  logic [P9_W-1:0] p9_mode_reg;
  logic [P9_W-1:0] p9_func_reg;
  logic [7:0] p9_od_reg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic access_lane_t lane_of(input logic [5:0] a, input logic [5:0] base);
    if (a == base) begin
      lane_of = ACC_WORD;
    end else if (a == base + 6'h01) begin
      lane_of = ACC_LOW;
    end else if (a == base + 6'h02) begin
      lane_of = ACC_HIGH;
    end else begin
      lane_of = ACC_NONE;
    end
  endfunction : lane_of

  // merge one written lane into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input access_lane_t ln,
                                          input logic [31:0] wd);
    unique case (ln)
      ACC_WORD: merge16 = wd[15:0];
      ACC_LOW: merge16 = {old[15:8], wd[7:0]};
      ACC_HIGH: merge16 = {wd[7:0], old[7:0]};
      default: merge16 = old;
    endcase
  endfunction : merge16

  // 16-bit read view: byte lanes land in the low bits
  function automatic logic [31:0] view16(input logic [15:0] v, input access_lane_t ln);
    unique case (ln)
      ACC_WORD: view16 = {16'h0000, v};
      ACC_LOW: view16 = {24'h000000, v[7:0]};
      ACC_HIGH: view16 = {24'h000000, v[15:8]};
      default: view16 = 32'h00000000;
    endcase
  endfunction : view16

  wire access_lane_t lane_latch = lane_of(reg_addr_i, `P9_LATCH_OFS);
  wire access_lane_t lane_dir = lane_of(reg_addr_i, `P9_DIR_OFS);
  wire access_lane_t lane_mode = lane_of(reg_addr_i, `P9_MODE_OFS);
  wire access_lane_t lane_func = lane_of(reg_addr_i, `P9_FUNC_OFS);

  wire logic [15:0] p9_latch_next = merge16(p9_latch_reg, lane_latch, reg_wdata_i); // see R8
  wire logic [15:0] p9_dir_next = merge16(p9_dir_reg, lane_dir, reg_wdata_i); // see R8
  wire logic [15:0] p9_mode_next = merge16(p9_mode_reg, lane_mode, reg_wdata_i); // see R11
  wire logic [15:0] p9_func_next = merge16(p9_func_reg, lane_func, reg_wdata_i); // see R12

  // ----------------------------------------------------------------
  // pin read view: pin level for inputs, latch for outputs
  // ----------------------------------------------------------------
  wire logic [P5_W-1:0] p5_view = (p5_dir_reg & p5_pin_i) | (~p5_dir_reg & p5_latch_reg); // see R15
  wire logic [P9_W-1:0] p9_view = (p9_dir_reg & p9_pin_i) | (~p9_dir_reg & p9_latch_reg); // see R15

  wire logic hit_p5 = reg_addr_i == `P5_DIR_OFS || reg_addr_i == `P5_MODE_OFS ||
                      reg_addr_i == `P5_FUNC_OFS || reg_addr_i == `P5_PIN_OFS ||
                      reg_addr_i == `P5_LATCH_OFS || reg_addr_i == `P7_PIN_OFS ||
                      reg_addr_i == `P9_OD_OFS;
  wire logic [31:0] rd_p5 =
    (reg_addr_i == `P5_DIR_OFS) ? {26'h0000000, p5_dir_reg} :
    (reg_addr_i == `P5_MODE_OFS) ? {26'h0000000, p5_mode_reg} :
    (reg_addr_i == `P5_FUNC_OFS) ? {26'h0000000, p5_func_reg} :
    (reg_addr_i == `P5_PIN_OFS) ? {26'h0000000, p5_view} :
    (reg_addr_i == `P5_LATCH_OFS) ? {26'h0000000, p5_latch_reg} :
    (reg_addr_i == `P7_PIN_OFS) ? {24'h000000, p7_pin_i} : // see R4
    {24'h000000, p9_od_reg};
  wire logic [31:0] rd_p9 = view16(p9_view, lane_latch) | view16(p9_dir_reg, lane_dir) |
                            view16(p9_mode_reg, lane_mode) | view16(p9_func_reg, lane_func);
  // unmapped addresses read zero
  wire logic [31:0] rd_next = hit_p5 ? rd_p5 : rd_p9;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // write enables of the single-byte registers
  wire logic we_p5_dir = reg_wr_i && reg_addr_i == `P5_DIR_OFS;
  wire logic we_p5_mode = reg_wr_i && reg_addr_i == `P5_MODE_OFS;
  wire logic we_p5_func = reg_wr_i && reg_addr_i == `P5_FUNC_OFS;
  wire logic we_p5_latch = reg_wr_i && reg_addr_i == `P5_LATCH_OFS;
  wire logic we_p9_od = reg_wr_i && reg_addr_i == `P9_OD_OFS;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p5_dir_reg <= `P5_DIR_RST; // see R1
    end else if (we_p5_dir) begin
      p5_dir_reg <= reg_wdata_i[P5_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p5_mode_reg <= `P5_MODE_RST; // see R2
    end else if (we_p5_mode) begin
      p5_mode_reg <= reg_wdata_i[P5_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p5_func_reg <= `P5_FUNC_RST; // see R3
    end else if (we_p5_func) begin
      p5_func_reg <= reg_wdata_i[P5_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p5_latch_reg <= `P5_LATCH_RST;
    end else if (we_p5_latch) begin
      p5_latch_reg <= reg_wdata_i[P5_W-1:0];
    end
  end

  // unused select bits stay zero so they never read back set
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p9_od_reg <= `P9_OD_RST; // see R13
    end else if (we_p9_od) begin
      p9_od_reg <= reg_wdata_i[7:0] & `OD_VALID_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p9_latch_reg <= `P9_LATCH_RST; // see R6
    end else if (reg_wr_i) begin
      p9_latch_reg <= p9_latch_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p9_dir_reg <= `P9_DIR_RST; // see R7
    end else if (reg_wr_i) begin
      p9_dir_reg <= p9_dir_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p9_mode_reg <= `P9_MODE_RST; // see R9
    end else if (reg_wr_i) begin
      p9_mode_reg <= p9_mode_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p9_func_reg <= `P9_FUNC_RST; // see R10
    end else if (reg_wr_i) begin
      p9_func_reg <= p9_func_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_next : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // pin muxing, narrow port
  // ----------------------------------------------------------------
  wire logic [P5_W-1:0] p5_out_d;
  wire logic [P5_W-1:0] p5_oe_d;
  for (genvar i = 0; i < P5_W; i++) begin : g_p5_pin
    // peripheral mode: function bit picks serial/timer or pulse output
    wire logic alt_out = p5_func_reg[i] ? realtime_pulse_out_i[i] : p5_periph_out_i[i]; // see R3
    wire logic alt_oe = p5_func_reg[i] | p5_periph_oe_i[i]; // see R3
    assign p5_out_d[i] = p5_mode_reg[i] ? alt_out : p5_latch_reg[i]; // see R2
    assign p5_oe_d[i] = p5_mode_reg[i] ? alt_oe : ~p5_dir_reg[i]; // see R1
  end

  // ----------------------------------------------------------------
  // pin muxing, wide port
  // ----------------------------------------------------------------
  wire logic [P9_W-1:0] od_mask = {3'h0, p9_od_reg[4:3], 1'b0, p9_od_reg[1:0], 8'h00}; // see R13
  wire logic [P9_W-1:0] p9_drv;
  wire logic [P9_W-1:0] p9_oe_d;
  for (genvar i = 0; i < P9_W; i++) begin : g_p9_pin
    // peripheral mode: a cleared function bit puts the address bit out
    wire logic alt_out = p9_func_reg[i] ? p9_periph_out_i[i] : ext_addr_i[i]; // see R10
    wire logic alt_oe = ~p9_func_reg[i] | p9_periph_oe_i[i]; // see R10
    wire logic en = p9_mode_reg[i] ? alt_oe : ~p9_dir_reg[i]; // see R5
    assign p9_drv[i] = p9_mode_reg[i] ? alt_out : p9_latch_reg[i]; // see R6
    // open drain: drive only the low level, release for a high
    assign p9_oe_d[i] = en & ~(od_mask[i] & p9_drv[i]);
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p5_pin_o <= '0;
      p5_pin_oe_o <= '0;
    end else begin
      p5_pin_o <= p5_out_d;
      p5_pin_oe_o <= p5_oe_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p9_pin_o <= '0;
      p9_pin_oe_o <= '0;
    end else begin
      p9_pin_o <= p9_drv & ~od_mask;
      p9_pin_oe_o <= p9_oe_d;
    end
  end

  // input taps: key-return inputs only in port mode, serial/timer inputs only in peripheral mode with the function bit clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p5_periph_in_o <= '0;
      key_return_input_o <= '0;
      analog_input_channel_o <= '0;
    end else begin
      p5_periph_in_o <= p5_pin_i & p5_mode_reg & ~p5_func_reg;
      key_return_input_o <= p5_pin_i & ~p5_mode_reg; // see R2
      analog_input_channel_o <= p7_pin_i; // see R4
    end
  end

  // wide taps: timer and key-return in port mode only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p9_periph_in_o <= '0;
      timer_capture_input_o <= '0;
      p9_key_return_o <= '0;
    end else begin
      p9_periph_in_o <= p9_pin_i & p9_mode_reg & p9_func_reg;
      timer_capture_input_o <= {p9_pin_i[6], p9_pin_i[4], p9_pin_i[2]} &
                               ~{p9_mode_reg[6], p9_mode_reg[4], p9_mode_reg[2]}; // see R9
      p9_key_return_o <= p9_pin_i[1:0] & ~p9_mode_reg[1:0]; // see R9
    end
  end

  // interrupt inputs only in peripheral mode with the function bit set
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      external_interrupt_input_o <= '0;
    end else begin
      external_interrupt_input_o <= p9_pin_i[15:13] & p9_mode_reg[15:13] &
                                    p9_func_reg[15:13]; // see R10
    end
  end

endmodule : port_pin_function_select

// file: port_pin_regs.svh
// register offsets, field positions and reset values of the port pin function block
// Functional notes
// R1 - narrow direction bit: 0 output, 1 input
// R2 - narrow mode control resets 0, peripheral when set
// R3 - narrow function bit: serial/timer or pulse output
// R4 - eight-bit input-only port feeding analog channels
// R5 - wide port sixteen bits, per-bit direction
// R6 - wide latch resets zero, drives output pins
// R7 - wide direction resets all ones, zero outputs
// R8 - wide registers word, byte or bit access; code gives word and byte lanes only, no bit access
// R9 - wide mode control zero, port taps to timers/keys
// R10 - wide function bit: address bit or peripheral
// R11 - software writes mode all ones for address bus
// R12 - software writes function zeros for address bus
// R13 - open-drain select resets zero, bits 8,9,11,12
// R14 - software sets latch high before open drain
// R15 - reads return pin if input, latch if output
`ifndef PORT_PIN_REGS_SVH
`define PORT_PIN_REGS_SVH

// ----------------------------------------------------------------
// register offsets (word index, byte address is four times)
// ----------------------------------------------------------------
`define P5_DIR_OFS 6'h00
`define P5_MODE_OFS 6'h01
`define P5_FUNC_OFS 6'h02
`define P5_PIN_OFS 6'h03
`define P7_PIN_OFS 6'h04
`define P9_LATCH_OFS 6'h08
`define P9_LATCH_L_OFS 6'h09
`define P9_LATCH_H_OFS 6'h0A
`define P9_DIR_OFS 6'h0C
`define P9_DIR_L_OFS 6'h0D
`define P9_DIR_H_OFS 6'h0E
`define P9_MODE_OFS 6'h10
`define P9_MODE_L_OFS 6'h11
`define P9_MODE_H_OFS 6'h12
`define P9_FUNC_OFS 6'h14
`define P9_FUNC_L_OFS 6'h15
`define P9_FUNC_H_OFS 6'h16
`define P9_OD_OFS 6'h18
`define P5_LATCH_OFS 6'h1C

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define P5_DIR_RST 6'h3F
`define P5_MODE_RST 6'h00
`define P5_FUNC_RST 6'h00
`define P5_LATCH_RST 6'h00
`define P9_LATCH_RST 16'h0000
`define P9_DIR_RST 16'hFFFF
`define P9_MODE_RST 16'h0000
`define P9_FUNC_RST 16'h0000
`define P9_OD_RST 8'h00

// ----------------------------------------------------------------
// open-drain select field positions (wide port bit numbers)
// ----------------------------------------------------------------
`define OD_BIT_A 8
`define OD_BIT_B 9
`define OD_BIT_C 11
`define OD_BIT_D 12
`define OD_VALID_MASK 8'h1B

`endif

// file: port_pin_pkg.sv
// types of the port pin function block
package port_pin_pkg;
  typedef enum logic [1:0] {
    ACC_WORD = 2'h0,
    ACC_LOW = 2'h1,
    ACC_HIGH = 2'h2,
    ACC_NONE = 2'h3
  } access_lane_t;
endpackage : port_pin_pkg

// file: port_pin_sva.sv
// assertions on the port pin function block ports
`timescale 1ns/1ps
`include "port_pin_regs.svh"

module port_pin_sva (
  // clock, reset and register port
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // pin and peripheral side
  input wire logic [5:0] p5_pin_i,
  input wire logic [5:0] p5_periph_in_o,
  input wire logic [5:0] key_return_input_o,
  input wire logic [7:0] p7_pin_i,
  input wire logic [7:0] analog_input_channel_o,
  input wire logic [15:0] p9_periph_in_o,
  input wire logic [2:0] timer_capture_input_o,
  input wire logic [1:0] p9_key_return_o,
  input wire logic [2:0] external_interrupt_input_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // ----
  // write then read sequences
  // ----
  sequence s_dir_wr_rd;
    reg_wr_i && reg_addr_i == `P9_DIR_OFS ##1 reg_rd_i && reg_addr_i == `P9_DIR_OFS;
  endsequence
  sequence s_hi_wr_rd;
    reg_wr_i && reg_addr_i == `P9_MODE_H_OFS ##1 reg_rd_i && reg_addr_i == `P9_MODE_OFS;
  endsequence
  // ----
  // properties
  // ----
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_p7; !$past(rst_i) |-> analog_input_channel_o == $past(p7_pin_i); endproperty
  a_p7: assert property (p_p7) else $error("analog channel not pin copy");
  property p_p5_key;
    !$past(rst_i) |-> (key_return_input_o & ~$past(p5_pin_i)) == 6'h00;
  endproperty
  a_p5_key: assert property (p_p5_key) else $error("key return not pin level");
  property p_p5_excl;
    (p5_periph_in_o & key_return_input_o) == 6'h00;
  endproperty
  a_p5_excl: assert property (p_p5_excl) else $error("narrow port and peripheral both");
  property p_p9_irq; external_interrupt_input_o == p9_periph_in_o[15:13]; endproperty
  a_p9_irq: assert property (p_p9_irq) else $error("interrupt input mismatch");
  property p_p9_excl;
    (p9_key_return_o & p9_periph_in_o[1:0]) == 2'h0 &&
    (timer_capture_input_o & {p9_periph_in_o[6], p9_periph_in_o[4], p9_periph_in_o[2]}) == 3'h0;
  endproperty
  a_p9_excl: assert property (p_p9_excl) else $error("port taps in peripheral mode");
  property p_dir; s_dir_wr_rd |=> reg_rdata_o[15:0] == $past(reg_wdata_i[15:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction readback wrong");
  property p_hi; s_hi_wr_rd |=> reg_rdata_o[15:8] == $past(reg_wdata_i[7:0], 2); endproperty
  a_hi: assert property (p_hi) else $error("high byte lane wrong");
endmodule : port_pin_sva

// file: pin_partner.sv
// pad model: driven pins follow the block, released pins show the far-side level
`timescale 1ns/1ps

module pin_partner (
  // narrow port
  input wire logic [5:0] drv5_i,
  input wire logic [5:0] oe5_i,
  input wire logic [5:0] far5_i,
  output logic [5:0] pin5_o,
  // wide port
  input wire logic [15:0] drv9_i,
  input wire logic [15:0] oe9_i,
  input wire logic [15:0] far9_i,
  output logic [15:0] pin9_o
);
  // released pins never echo the last driven value
  assign pin5_o = (drv5_i & oe5_i) | (far5_i & ~oe5_i);
  assign pin9_o = (drv9_i & oe9_i) | (far9_i & ~oe9_i);
endmodule : pin_partner

// file: tb_port_pin_function_select.sv
// self-checking bench for the port pin function block
`timescale 1ns/1ps
`include "port_pin_regs.svh"

module tb_port_pin_function_select;
  logic core_clk_i = 0;
  logic rst_i = 1;
  logic [5:0] reg_addr_i = 6'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic [31:0] reg_rdata_o;
  logic [5:0] p5_pin_i, p5_pin_o, p5_pin_oe_o, p5_pin_in, key5;
  logic [5:0] p5_ext = 6'h2D, p5_po = 6'h15, p5_poe = 6'h3F, rtp = 6'h2A;
  logic [7:0] p7 = 8'hC6, ana;
  logic [15:0] p9_pin_i, p9_pin_o, p9_pin_oe_o, p9_in, p9_ext = 16'h6B92;
  logic [15:0] ext_addr = 16'h3C5A, p9_po = 16'h0F0F, p9_poe = 16'h0000;
  logic [2:0] tmr, irq;
  logic [1:0] kr9;
  int n_errors = 0;
  int cmp_count = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  port_pin_function_select dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .p5_pin_i(p5_pin_i), .p5_pin_o(p5_pin_o),
    .p5_pin_oe_o(p5_pin_oe_o), .p5_periph_out_i(p5_po), .p5_periph_oe_i(p5_poe),
    .realtime_pulse_out_i(rtp), .p5_periph_in_o(p5_pin_in), .key_return_input_o(key5),
    .p7_pin_i(p7), .analog_input_channel_o(ana), .p9_pin_i(p9_pin_i), .p9_pin_o(p9_pin_o),
    .p9_pin_oe_o(p9_pin_oe_o), .ext_addr_i(ext_addr), .p9_periph_out_i(p9_po),
    .p9_periph_oe_i(p9_poe), .p9_periph_in_o(p9_in), .timer_capture_input_o(tmr),
    .p9_key_return_o(kr9), .external_interrupt_input_o(irq));
  pin_partner pp_u (.drv5_i(p5_pin_o), .oe5_i(p5_pin_oe_o), .far5_i(p5_ext), .pin5_o(p5_pin_i),
    .drv9_i(p9_pin_o), .oe9_i(p9_pin_oe_o), .far9_i(p9_ext), .pin9_o(p9_pin_i));
  // ----
  // bus tasks and comparison
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // strobe stays high so a read may follow with no gap
  task wr(input logic [5:0] a, input logic [31:0] d);
    reg_rd_i <= 0;
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
  endtask : wr
  task rd(input logic [5:0] a, input logic [31:0] e);
    reg_wr_i <= 0;
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 0;
    #1;
    chk("rdata", reg_rdata_o, e);
    @(posedge core_clk_i);
  endtask : rd
  // pins lag the register by one cycle
  task settle;
    reg_wr_i <= 0;
    reg_rd_i <= 0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask : settle
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 0;
    @(posedge core_clk_i);
    rd(`P5_DIR_OFS, 32'h3F);
    rd(`P5_MODE_OFS, 32'h0);
    rd(`P5_FUNC_OFS, 32'h0);
    rd(`P9_DIR_OFS, 32'hFFFF);
    rd(`P9_MODE_OFS, 32'h0);
    rd(`P9_FUNC_OFS, 32'h0);
    rd(`P9_OD_OFS, 32'h0);
    rd(`P9_LATCH_OFS, 32'(p9_ext));
    rd(6'h3F, 32'h0);
    chk("key5", 32'(key5), 32'(p5_ext));
    wr(`P9_DIR_OFS, 32'h00FF);
    rd(`P9_DIR_OFS, 32'h00FF);
    settle;
    chk("p9_oe", 32'(p9_pin_oe_o), 32'hFF00);
    chk("p9_o", 32'(p9_pin_o[15:8]), 32'h0);
    wr(`P9_LATCH_L_OFS, 32'h12);
    wr(`P9_LATCH_H_OFS, 32'hA5);
    rd(`P9_LATCH_OFS, {16'h0, 8'hA5, p9_ext[7:0]});
    wr(`P9_LATCH_H_OFS, 32'hFF);
    wr(`P9_OD_OFS, 32'hFF);
    rd(`P9_OD_OFS, 32'h1B);
    settle;
    chk("p9_od", 32'(p9_pin_oe_o), 32'hE400);
    wr(`P9_OD_OFS, 32'h0);
    wr(`P9_MODE_OFS, 32'hFFFF);
    wr(`P9_FUNC_OFS, 32'h0);
    settle;
    chk("addr", {p9_pin_oe_o, p9_pin_o}, {16'hFFFF, ext_addr});
    p9_poe <= 16'hFFFF;
    wr(`P9_FUNC_OFS, 32'hFFFF);
    settle;
    chk("p9_per", 32'(p9_pin_o), 32'(p9_po));
    p9_poe <= 16'h0000;
    p9_ext <= 16'hD4E5;
    settle;
    chk("p9_in", {13'h0, irq, p9_in}, {13'h0, p9_ext[15:13], p9_ext});
    wr(`P9_MODE_H_OFS, 32'h0);
    rd(`P9_MODE_OFS, 32'h00FF);
    wr(`P9_MODE_L_OFS, 32'h0);
    settle;
    chk("taps", {27'h0, tmr, kr9}, 32'({p9_ext[6], p9_ext[4], p9_ext[2], p9_ext[1:0]}));
    wr(`P5_MODE_OFS, 32'h3F);
    settle;
    chk("p5_per", {p5_pin_in, p5_pin_o}, {p5_po, p5_po});
    wr(`P5_FUNC_OFS, 32'h3F);
    settle;
    chk("p5_rtp", {p5_pin_in, p5_pin_oe_o, p5_pin_o}, {6'h0, 6'h3F, rtp});
    wr(`P5_MODE_OFS, 32'h0);
    wr(`P5_LATCH_OFS, 32'h0B);
    wr(`P5_DIR_OFS, 32'h0);
    p7 <= 8'h39;
    settle;
    chk("p5_out", {key5, p5_pin_oe_o, p5_pin_o}, {6'h0B, 6'h3F, 6'h0B});
    chk("ana", 32'(ana), 32'h39);
    complete_run();
  end
endmodule : tb_port_pin_function_select

bind port_pin_function_select port_pin_sva chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .p5_pin_i(p5_pin_i),
  .p5_periph_in_o(p5_periph_in_o), .key_return_input_o(key_return_input_o),
  .p7_pin_i(p7_pin_i), .analog_input_channel_o(analog_input_channel_o),
  .p9_periph_in_o(p9_periph_in_o), .timer_capture_input_o(timer_capture_input_o),
  .p9_key_return_o(p9_key_return_o), .external_interrupt_input_o(external_interrupt_input_o));
